// >>> design/trg_pkg.sv
// Purpose: shared constants for the tone ringer core
// Assumes: 40 MHz hclk, both RC oscillators arrive as pins synchronous to hclk
// Notes:
package trg_pkg;
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          RATE_OSC_HZ   = 5120;
  localparam int          SHIFT_HZ      = 16;
  localparam int          DPR_HZ        = 8;
  localparam int          SHIFT_DIV     = RATE_OSC_HZ / SHIFT_HZ;
  localparam int          DPR_DIV       = RATE_OSC_HZ / DPR_HZ;
  localparam int          NOISE_US      = 2000;
  localparam int          NOISE_CYC     = (NOISE_US * (CLK_HZ / 1_000_000) + 0);
  localparam int          SILENCE_MS    = 5000;
  localparam int          SILENCE_TICKS = SILENCE_MS * RATE_OSC_HZ / 1000;
  localparam int          DPR_MIN_EDGES = 2;
  localparam logic [2:0]  TONE_DIV_HI   = 3'h4;
  localparam logic [2:0]  TONE_DIV_LO   = 3'h5;
  localparam logic [1:0]  RING_MAX      = 2'h3;
  localparam logic [1:0]  RING_SECOND   = 2'h2;
  // register map
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STAT_OFS      = 8'h04;
  localparam int          CTRL_MANUAL   = 0;
  localparam int          CTRL_SINGLE_N = 1;
  localparam int          CTRL_BYPASS   = 2;
  localparam int          CTRL_THR_OVR  = 3;
  localparam logic [3:0]  CTRL_RESET    = 4'h2;
  localparam int          STAT_RINGING  = 0;
  localparam int          STAT_RING_LSB = 1;
  localparam int          STAT_DETECT   = 3;
  localparam int          STAT_SUPPLY   = 4;
  localparam int          STAT_TONE_LO  = 5;
endpackage : trg_pkg

// >>> design/trg_ring_detect.sv
// Purpose: noise filter and dial-pulse reject filter on the ring input
// Assumes: dpr_tick is a one-cycle pulse at 8 Hz, ring_in synchronous to hclk
// Notes: a ring must show enough edges in one whole 8 Hz period before it counts
`timescale 1ns/1ps
`default_nettype none
module trg_ring_detect
  import trg_pkg::*;
#(
  parameter int NOISE_CYCLES = NOISE_CYC,
  parameter int MIN_EDGES    = DPR_MIN_EDGES
) (
  input  wire logic hclk,       // system clock
  input  wire logic hresetn,    // async reset, active low
  input  wire logic ring_in,    // squared ring enable level
  input  wire logic dpr_tick,   // 8 Hz filter clock pulse
  output logic      ring_det    // filtered ring detection
);
  localparam int NW = $clog2(NOISE_CYCLES + 1);
  localparam int EW = $clog2(MIN_EDGES + 1);

  if (NOISE_CYCLES < 1 || MIN_EDGES < 1) begin : g_bad_param
    $error("trg_ring_detect: parameters must be at least one");
  end

  logic [NW-1:0] noise_cnt_ff;
  logic          filt_ff;
  logic          filt_prev_ff;
  logic [EW-1:0] edge_cnt_ff;
  logic          det_ff;

  wire           differs   = ring_in != filt_ff;
  wire           settle    = differs && (noise_cnt_ff == NW'(NOISE_CYCLES - 1));
  wire           filt_rise = filt_ff && !filt_prev_ff;
  wire           edges_ok  = edge_cnt_ff >= EW'(MIN_EDGES);

  // a change is taken only after it has held for the whole filter time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      noise_cnt_ff <= '0;
      filt_ff      <= 1'b0;
    end else begin
      noise_cnt_ff <= (differs && !settle) ? noise_cnt_ff + NW'(1) : '0;
      if (settle) filt_ff <= ring_in;
    end
  end

  // edges are counted per 8 Hz window; fewer than two means below 16 Hz
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_prev_ff <= 1'b0;
      edge_cnt_ff  <= '0;
      det_ff       <= 1'b0;
    end else begin
      filt_prev_ff <= filt_ff;
      if (dpr_tick) begin
        det_ff      <= edges_ok;
        edge_cnt_ff <= '0;
      end else if (filt_rise && !edges_ok) begin
        edge_cnt_ff <= edge_cnt_ff + EW'(1);
      end
    end
  end

  assign ring_det = det_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_noise_hold;
    $changed(filt_ff) |-> $past(ring_in) == filt_ff && $past(differs);
  endproperty
  a_noise_hold: assert property (p_noise_hold) else $error("filter output moved without a settled input");

  property p_det_on_tick;
    $rose(det_ff) |-> $past(dpr_tick) && $past(edge_cnt_ff) >= EW'(MIN_EDGES);
  endproperty
  a_det_on_tick: assert property (p_det_on_tick) else $error("detection rose off the 8 Hz tick");
endmodule : trg_ring_detect
`default_nettype wire

// >>> design/trg_tone_ringer.sv
// Purpose: tone ringer core: ring detect, warble tone, amplitude sequencing, AHB-Lite registers
// Assumes: rate and tone oscillator pins and ring pin are synchronous to hclk
// Notes: three-state outputs are given as data plus enable; the bench checks data and enable as separate signals
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module trg_tone_ringer
  import trg_pkg::*;
#(
  parameter int NOISE_CYCLES   = NOISE_CYC,
  parameter int SILENCE_RATE   = SILENCE_TICKS,
  parameter int SHIFT_RATE_DIV = SHIFT_DIV,
  parameter int DPR_RATE_DIV   = DPR_DIV
) (
  input  wire logic        hclk,         // AHB clock
  input  wire logic        hresetn,      // async reset, active low
  input  wire logic        hsel,         // slave select
  input  wire logic [31:0] haddr,        // byte address
  input  wire logic [1:0]  htrans,       // transfer type
  input  wire logic        hwrite,       // write strobe
  input  wire logic [2:0]  hsize,        // transfer size
  input  wire logic [31:0] hwdata,       // write data
  input  wire logic        hready,       // bus ready in
  output logic [31:0]      hrdata,       // read data
  output logic             hreadyout,    // slave ready
  output logic             hresp,        // always OKAY
  input  wire logic        ring_en,      // ring enable pin level
  input  wire logic        supply_ok,    // supply above threshold
  input  wire logic        rate_osc,     // rate oscillator pin
  input  wire logic        tone_osc,     // tone oscillator pin
  output logic             out_h,        // high-side buffer data
  output logic             out_h_oe,     // high-side buffer enable
  output logic             out_c,        // complement buffer data
  output logic             out_c_oe,     // complement buffer enable
  output logic             out_l,        // low-level buffer data
  output logic             out_l_oe,     // low-level buffer enable
  output logic             out_m,        // mid-level buffer data
  output logic             out_m_oe      // mid-level buffer enable
);
  localparam int SHW = $clog2(SHIFT_RATE_DIV);
  localparam int DPW = $clog2(DPR_RATE_DIV);
  localparam int SLW = $clog2(SILENCE_RATE + 1);

  if (SHIFT_RATE_DIV < 2 || DPR_RATE_DIV < 2 || SILENCE_RATE < 1) begin : g_bad_param
    $error("trg_tone_ringer: divider parameters out of range");
  end

  // register slave on AHB-Lite, zero wait states
  logic [3:0]  ctrl_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] hrdata_ff;

  wire        accept     = hsel && hready && htrans[1];
  wire [7:0]  ofs        = haddr[7:0];
  wire        hit_ctrl   = haddr[31:8] == 24'h000000 && ofs == CTRL_OFS;
  wire        hit_stat   = haddr[31:8] == 24'h000000 && ofs == STAT_OFS;
  wire        wr_ctrl    = wr_pend_ff && wr_addr_ff == CTRL_OFS;
  wire        manual     = ctrl_ff[CTRL_MANUAL];
  wire        single_n   = ctrl_ff[CTRL_SINGLE_N];
  wire        bypass     = ctrl_ff[CTRL_BYPASS];
  wire        thr_ovr    = ctrl_ff[CTRL_THR_OVR];
  logic [31:0] stat_word;
  wire [31:0] rd_word    = hit_ctrl ? {28'h0000000, ctrl_ff} : (hit_stat ? stat_word : 32'h00000000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h00000000;
    end else if (hready) begin
      wr_pend_ff <= accept && hwrite && (hit_ctrl || hit_stat);
      wr_addr_ff <= ofs;
      if (accept && !hwrite) hrdata_ff <= rd_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl_ff <= CTRL_RESET;
    else if (wr_ctrl) ctrl_ff <= hwdata[3:0];
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // time bases from the two oscillator pins
  logic           rate_prev_ff;
  logic           tone_prev_ff;
  logic [SHW-1:0] shift_cnt_ff;
  logic [DPW-1:0] dpr_cnt_ff;

  wire run       = supply_ok || thr_ovr;
  wire rate_tick = run && rate_osc && !rate_prev_ff;
  wire tone_tick = run && tone_osc && !tone_prev_ff;
  wire shift_end = shift_cnt_ff == SHW'(SHIFT_RATE_DIV - 1);
  wire dpr_end   = dpr_cnt_ff == DPW'(DPR_RATE_DIV - 1);
  wire shift_tick = rate_tick && shift_end;
  wire dpr_tick   = rate_tick && dpr_end;

  // oscillator pins are only edge-detected; they are not clocks here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_prev_ff <= 1'b0;
      tone_prev_ff <= 1'b0;
      shift_cnt_ff <= '0;
      dpr_cnt_ff   <= '0;
    end else begin
      rate_prev_ff <= rate_osc;
      tone_prev_ff <= tone_osc;
      if (rate_tick) begin
        shift_cnt_ff <= shift_end ? '0 : shift_cnt_ff + SHW'(1);
        dpr_cnt_ff   <= dpr_end ? '0 : dpr_cnt_ff + DPW'(1);
      end
    end
  end

  // warble tone
  logic [2:0] divisor_ff;
  logic [2:0] tone_cnt_ff;
  logic       tone_ff;

  wire [2:0] nxt_divisor = !single_n ? TONE_DIV_HI :
                           (shift_tick ? ((divisor_ff == TONE_DIV_HI) ? TONE_DIV_LO : TONE_DIV_HI) : divisor_ff);
  wire       tone_wrap   = tone_cnt_ff >= divisor_ff - 3'h1;

  // the half period ends on a compare, so a shrinking divisor cannot strand the count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      divisor_ff  <= TONE_DIV_HI;
      tone_cnt_ff <= 3'h0;
      tone_ff     <= 1'b0;
    end else begin
      divisor_ff <= nxt_divisor;
      if (tone_tick) begin
        tone_cnt_ff <= tone_wrap ? 3'h0 : tone_cnt_ff + 3'h1;
        if (tone_wrap) tone_ff <= !tone_ff;
      end
    end
  end

  // ring detection and amplitude sequencing
  logic           det;
  logic           ring_q_ff;
  logic [1:0]     ring_num_ff;
  logic [SLW-1:0] silence_ff;

  trg_ring_detect #(
    .NOISE_CYCLES (NOISE_CYCLES),
    .MIN_EDGES    (DPR_MIN_EDGES)
  ) trg_ring_detect_inst (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ring_in  (ring_en),
    .dpr_tick (dpr_tick),
    .ring_det (det)
  );

  wire ring_active = bypass ? ring_en : det;
  wire ringing     = ring_active && run;
  wire ring_start  = ringing && !ring_q_ff;
  wire silent_long = silence_ff == SLW'(SILENCE_RATE);

  // silence is timed on rate edges, so it stops when the supply drops below threshold and CTRL_THR_OVR is clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ring_q_ff   <= 1'b0;
      ring_num_ff <= 2'h0;
      silence_ff  <= '0;
    end else begin
      ring_q_ff <= ringing;
      if (ringing) silence_ff <= '0;
      else if (rate_tick && !silent_long) silence_ff <= silence_ff + SLW'(1);
      if (manual) ring_num_ff <= 2'h0;
      else if (ring_start && ring_num_ff != RING_MAX) ring_num_ff <= ring_num_ff + 2'h1;
      else if (silent_long && !ringing) ring_num_ff <= 2'h0;
    end
  end

  // output stage
  logic out_h_ff, out_c_ff, out_l_ff, out_m_ff;
  logic oe_h_ff, oe_c_ff, oe_l_ff, oe_m_ff;

  wire       tone_on   = ringing && tone_ff;
  wire [1:0] num_now   = ring_start && !manual && ring_num_ff != RING_MAX ? ring_num_ff + 2'h1 : ring_num_ff;
  wire       nxt_oe_h  = manual || num_now == RING_MAX;
  wire       nxt_oe_m  = !manual && ringing && num_now == RING_SECOND;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_h_ff <= 1'b0;
      out_c_ff <= 1'b0;
      out_l_ff <= 1'b0;
      out_m_ff <= 1'b0;
      oe_h_ff  <= 1'b0;
      oe_c_ff  <= 1'b0;
      oe_l_ff  <= 1'b0;
      oe_m_ff  <= 1'b0;
    end else begin
      out_h_ff <= tone_on;
      out_c_ff <= ringing && !tone_ff;
      out_l_ff <= tone_on;
      out_m_ff <= tone_on;
      oe_h_ff  <= nxt_oe_h;
      oe_c_ff  <= 1'b1;
      oe_l_ff  <= 1'b1;
      oe_m_ff  <= nxt_oe_m;
    end
  end

  assign out_h    = out_h_ff;
  assign out_c    = out_c_ff;
  assign out_l    = out_l_ff;
  assign out_m    = out_m_ff;
  assign out_h_oe = oe_h_ff;
  assign out_c_oe = oe_c_ff;
  assign out_l_oe = oe_l_ff;
  assign out_m_oe = oe_m_ff;

  always_comb begin
    stat_word = 32'h00000000;
    stat_word[STAT_RINGING] = ring_q_ff;
    stat_word[STAT_RING_LSB +: 2] = ring_num_ff;
    stat_word[STAT_DETECT] = det;
    stat_word[STAT_SUPPLY] = supply_ok;
    stat_word[STAT_TONE_LO] = divisor_ff == TONE_DIV_LO;
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_shift_seen;
    shift_tick && single_n;
  endsequence
  sequence s_divisor_swapped;
    ##1 divisor_ff != $past(divisor_ff) && (divisor_ff == TONE_DIV_HI || divisor_ff == TONE_DIV_LO);
  endsequence

  property p_swap;
    s_shift_seen |-> s_divisor_swapped;
  endproperty
  a_swap: assert property (p_swap) else $error("divisor did not swap on shift tick");

  property p_hold_between_shifts;
    single_n && !shift_tick && $past(single_n) |=> $stable(divisor_ff);
  endproperty
  a_hold_between_shifts: assert property (p_hold_between_shifts) else $error("divisor moved between shift ticks");

  property p_single;
    !single_n |=> divisor_ff == TONE_DIV_HI;
  endproperty
  a_single: assert property (p_single) else $error("single tone mode left divisor four");

  property p_no_run;
    !run |=> $stable(tone_cnt_ff) && $stable(shift_cnt_ff);
  endproperty
  a_no_run: assert property (p_no_run) else $error("oscillators ran below threshold");

  property p_bypass;
    bypass && run |-> ringing == ring_en;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not follow enable");

  property p_antiphase;
    ring_q_ff |-> out_h_ff != out_c_ff;
  endproperty
  a_antiphase: assert property (p_antiphase) else $error("high and complement not in antiphase");

  property p_quiet;
    !ring_q_ff |-> !out_h_ff && !out_c_ff && !out_l_ff && !out_m_ff;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output high while not ringing");

  property p_mid;
    oe_m_ff |-> !$past(manual) && ring_q_ff && ring_num_ff == RING_SECOND;
  endproperty
  a_mid: assert property (p_mid) else $error("mid buffer drove outside second ring");

  property p_high_auto;
    !manual && !$past(manual) && ring_num_ff != RING_MAX && !ring_start |=> !oe_h_ff;
  endproperty
  a_high_auto: assert property (p_high_auto) else $error("high buffer drove before third ring");

  property p_manual;
    manual ##1 manual |-> oe_h_ff && oe_l_ff && oe_c_ff && !oe_m_ff && ring_num_ff == 2'h0;
  endproperty
  a_manual: assert property (p_manual) else $error("manual mode buffers or counter wrong");

  property p_count;
    ring_start && !manual && ring_num_ff != RING_MAX |=> ring_num_ff == $past(ring_num_ff) + 2'h1;
  endproperty
  a_count: assert property (p_count) else $error("ring not counted on detection rise");

  property p_silence;
    !manual && silent_long && !ringing && !ring_start |=> ring_num_ff == 2'h0;
  endproperty
  a_silence: assert property (p_silence) else $error("counter not reset after long silence");
endmodule : trg_tone_ringer
`default_nettype wire

// >>> testbench/trg_line_model.sv
// Purpose: line-side partner: ring signal source plus both RC oscillator pins
// Assumes: oscillators are far slower than hclk, ring pattern is set by the bench
// Notes: rate pin edge every 5 cycles, tone pin edge every 3 cycles, both free running
`timescale 1ns/1ps
`default_nettype none
module trg_line_model (
  input  wire logic        hclk,       // system clock
  input  wire logic [1:0]  ring_mode,  // 0 idle, 1 steady high, 2 toggling
  input  wire logic [15:0] ring_half,  // toggle half period in hclk cycles
  output logic             ring_en,    // ring enable line
  output logic             rate_osc,   // rate oscillator pin
  output logic             tone_osc    // tone oscillator pin
);
  logic [15:0] ring_cnt;
  logic [2:0]  rate_cnt;
  logic [1:0]  tone_cnt;

  initial begin
    ring_en  = 1'b0;
    rate_osc = 1'b0;
    tone_osc = 1'b0;
    ring_cnt = 16'h0000;
    rate_cnt = 3'h0;
    tone_cnt = 2'h0;
  end

  // fixed ratio between the two pins keeps expected tone lengths exact
  always @(posedge hclk) begin
    rate_cnt <= (rate_cnt == 3'h4) ? 3'h0 : rate_cnt + 3'h1;
    if (rate_cnt == 3'h4) rate_osc <= ~rate_osc;
    tone_cnt <= (tone_cnt == 2'h2) ? 2'h0 : tone_cnt + 2'h1;
    if (tone_cnt == 2'h2) tone_osc <= ~tone_osc;
    if (ring_mode == 2'h2) begin
      ring_cnt <= (ring_cnt >= ring_half - 16'h0001) ? 16'h0000 : ring_cnt + 16'h0001;
      if (ring_cnt >= ring_half - 16'h0001) ring_en <= ~ring_en;
    end else begin
      ring_cnt <= 16'h0000;
      ring_en  <= (ring_mode == 2'h1);
    end
  end
endmodule // trg_line_model
`default_nettype wire

// >>> testbench/trg_tone_ringer_tb.sv
// Purpose: self-checking bench for the tone ringer core
// Assumes: shortened counts: noise 20 cycles, silence 50 rate edges, shift 8, window 16
// Notes: one window is 160 cycles, so a 60-cycle ring period gives at least two rises per window
`timescale 1ns/1ps
`default_nettype none
module trg_tone_ringer_tb
  import trg_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, supply_ok;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, ring_mode;
  logic [2:0]  hsize;
  logic [15:0] ring_half;
  logic        hreadyout, hresp, ring_en, rate_osc, tone_osc;
  logic        out_h, out_h_oe, out_c, out_c_oe, out_l, out_l_oe, out_m, out_m_oe;
  logic        ring_seen;
  int          bad_count, comparisons, hi_len, n24, n30;
  localparam logic [31:0] MASK = ~(32'h1 << STAT_TONE_LO);

  trg_tone_ringer #(.NOISE_CYCLES(20), .SILENCE_RATE(50), .SHIFT_RATE_DIV(8), .DPR_RATE_DIV(16))
  trg_tone_ringer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ring_en(ring_en), .supply_ok(supply_ok),
    .rate_osc(rate_osc), .tone_osc(tone_osc), .out_h(out_h), .out_h_oe(out_h_oe), .out_c(out_c),
    .out_c_oe(out_c_oe), .out_l(out_l), .out_l_oe(out_l_oe), .out_m(out_m), .out_m_oe(out_m_oe));
  trg_line_model trg_line_model_inst (.hclk(hclk), .ring_mode(ring_mode), .ring_half(ring_half),
    .ring_en(ring_en), .rate_osc(rate_osc), .tone_osc(tone_osc));

  initial hclk = 1'b0;
  always #12.5 hclk = ~hclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("counts: compares=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic run(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // waits for hready at the next edges; a hung slave ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    hsel   <= 1'b1;
    haddr  <= addr;
    hwrite <= wr;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    wait_ready();
    rd = hrdata;
  endtask

  // one ring of 600 cycles, checked mid-ring and after the gap
  task automatic ring_chk(input logic [1:0] n, input logic m_oe, input logic h_oe);
    ring_half <= 16'd30;
    ring_mode <= 2'h2;
    run(450);
    ahb(1'b0, {24'h0, STAT_OFS}, 32'h0);
    chk(rd & MASK, (32'h1 << STAT_RINGING) | ({30'h0, n} << STAT_RING_LSB) | (32'h1 << STAT_DETECT)
      | (32'h1 << STAT_SUPPLY));
    chk(out_m_oe, m_oe);
    chk(out_h_oe, h_oe);
    chk(out_l_oe, 1'b1);
    run(150);
    ring_mode <= 2'h0;
    run(400);
    chk({out_h, out_c, out_l, out_m}, 4'h0);
    chk(out_m_oe, 1'b0);
  endtask

  // tone half-period lengths and antiphase of the load pair
  always @(posedge hclk) begin
    if (out_l === 1'b1 || out_c === 1'b1) ring_seen = 1'b1;
    if (out_h === 1'b1) chk(out_c, 1'b0);
    if (out_c === 1'b1) chk(out_h, 1'b0);
    if (out_c === 1'b1) hi_len++;
    else begin
      if (hi_len == 24) n24++;
      if (hi_len == 30) n30++;
      hi_len = 0;
    end
  end

  initial begin
    run(100000);
    bad_count++;
    report_and_stop();
  end

  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, ring_mode, ring_half} = '0;
    hsize = 3'h2;
    supply_ok = 1'b1;
    {bad_count, comparisons, hi_len, n24, n30, ring_seen} = '0;
    run(5);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({out_h, out_c, out_l, out_m, out_m_oe, out_h_oe}, 6'h00);
    ahb(1'b0, {24'h0, CTRL_OFS}, 32'h0);
    chk(rd, {28'h0, CTRL_RESET});
    chk(hresp, 1'b0);
    ahb(1'b1, {24'h0, CTRL_OFS}, 32'hFFFF_FFF2);
    ahb(1'b1, {24'h0, STAT_OFS}, 32'hFFFF_FFFF);
    ahb(1'b1, 32'h0000_0008, 32'hFFFF_FFFF);
    ahb(1'b0, {24'h0, STAT_OFS}, 32'h0);
    chk(rd & MASK, 32'h1 << STAT_SUPPLY);
    ahb(1'b0, 32'h0000_0008, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, {24'h0, CTRL_OFS}, 32'h0);
    chk(rd, 32'h2);
    $display("test registers done");
    // short burst, slow ring and noise glitches must all stay silent
    ring_half <= 16'd30;
    ring_mode <= 2'h2;
    run(70);
    ring_mode <= 2'h0;
    run(400);
    chk(ring_seen, 1'b0);
    ring_half <= 16'd200;
    ring_mode <= 2'h2;
    run(1200);
    ring_mode <= 2'h0;
    run(400);
    chk(ring_seen, 1'b0);
    ring_half <= 16'd8;
    ring_mode <= 2'h2;
    run(600);
    ring_mode <= 2'h0;
    run(400);
    chk(ring_seen, 1'b0);
    $display("test rejects done");
    ring_chk(2'h1, 1'b0, 1'b0);
    ring_chk(2'h2, 1'b1, 1'b0);
    ring_chk(2'h3, 1'b0, 1'b1);
    run(1000);
    ahb(1'b0, {24'h0, STAT_OFS}, 32'h0);
    chk(rd & MASK, 32'h1 << STAT_SUPPLY);
    chk(out_h_oe, 1'b0);
    $display("test auto sequence done");
    ahb(1'b1, {24'h0, CTRL_OFS}, 32'h3);
    run(2);
    chk({out_h_oe, out_c_oe, out_l_oe, out_m_oe}, 4'hE);
    ring_chk(2'h0, 1'b0, 1'b1);
    chk({out_h_oe, out_c_oe, out_l_oe, out_m_oe}, 4'hE);
    $display("test manual done");
    ahb(1'b1, {24'h0, CTRL_OFS}, 32'h4);
    {n24, n30} = '0;
    ring_mode <= 2'h1;
    run(400);
    ahb(1'b0, {24'h0, STAT_OFS}, 32'h0);
    chk(rd[STAT_RINGING], 1'b1);
    chk(rd[STAT_TONE_LO], 1'b0);
    chk(n30, 0);
    chk(n24 != 0, 1'b1);
    ahb(1'b1, {24'h0, CTRL_OFS}, 32'h6);
    {n24, n30} = '0;
    run(600);
    chk(n24 != 0, 1'b1);
    chk(n30 != 0, 1'b1);
    $display("test tone done");
    supply_ok <= 1'b0;
    run(5);
    ring_seen = 1'b0;
    run(200);
    chk(ring_seen, 1'b0);
    ahb(1'b1, {24'h0, CTRL_OFS}, 32'hE);
    run(200);
    chk(ring_seen, 1'b1);
    ring_mode <= 2'h0;
    supply_ok <= 1'b1;
    run(10);
    $display("test supply done");
    report_and_stop();
  end
endmodule // trg_tone_ringer_tb
`default_nettype wire
